/* verilog/llpcc_pkg.sv */
// Purpose: Shared constants for the line-locked pixel clock controller
// Assumes: 250 MHz core clock, APB register access, word index times four
// Notes:   Register offsets are word indices; byte address is index * 4
package llpcc_pkg;

  // Core clock
  localparam int unsigned CLK_MHZ        = 250;

  // Register word indices
  localparam logic [3:0]  IDX_INPUT_CTRL = 4'h0;
  localparam logic [3:0]  IDX_LOOP_CTRL  = 4'h1;
  localparam logic [3:0]  IDX_FB_LOW     = 4'h2;
  localparam logic [3:0]  IDX_FB_HIGH    = 4'h3;
  localparam logic [3:0]  IDX_IRQ_MASK   = 4'h4;
  localparam logic [3:0]  IDX_IRQ_STATUS = 4'h5;
  localparam logic [3:0]  IDX_LOCK_TOL   = 4'h6;
  localparam logic [3:0]  IDX_BUS_CTRL   = 4'h7;
  localparam logic [3:0]  IDX_COMMAND    = 4'h8;
  localparam logic [3:0]  IDX_LOOP_STAT  = 4'h9;
  localparam logic [3:0]  IDX_BUS_ADDR   = 4'hA;
  localparam logic [3:0]  IDX_IDENT      = 4'hB;
  localparam logic [3:0]  NUM_REGS       = 4'hC;

  // Input control fields
  localparam int unsigned BIT_PUMP_ALWAYS = 0;
  localparam int unsigned BIT_VS_POL      = 1;
  localparam int unsigned BIT_HS_POL      = 2;
  localparam int unsigned BIT_LOCK_OUT_EN = 6;
  localparam logic [7:0]  INPUT_CTRL_RST  = 8'h41;
  localparam logic [7:0]  INPUT_CTRL_WMSK = 8'h47;

  // Loop control fields
  localparam int unsigned PUMP_CUR_LSB   = 0;
  localparam int unsigned POST_DIV_LSB   = 4;
  localparam logic [7:0]  LOOP_CTRL_RST  = 8'h03;
  localparam logic [7:0]  LOOP_CTRL_WMSK = 8'h37;

  // Feedback divider
  localparam logic [7:0]  FB_LOW_RST     = 8'h04;
  localparam logic [3:0]  FB_HIGH_RST    = 4'h0;
  localparam logic [11:0] FB_MIN_WORD    = 12'h004;
  localparam logic [12:0] FB_OFFSET      = 13'h0008;

  // Interrupt status bits
  localparam int unsigned EV_LOCK_GAIN   = 0;
  localparam int unsigned EV_LOCK_LOSS   = 1;
  localparam int unsigned EV_COAST       = 2;
  localparam int unsigned NUM_EV         = 3;

  // Lock detection
  localparam int unsigned LOCK_TOL_NS    = 40;
  localparam logic [7:0]  LOCK_TOL_RST   = 8'((LOCK_TOL_NS * CLK_MHZ) / 1000);
  localparam logic [3:0]  LOCK_HITS      = 4'h8;
  localparam logic [3:0]  LOCK_MISSES    = 4'h4;

  // Power-on reset hold
  localparam int unsigned POR_NS         = 1000;
  localparam logic [15:0] POR_CYC        = 16'((POR_NS * CLK_MHZ + 999) / 1000);

  // Serial bus device addresses
  localparam logic [6:0]  BUS_ADDR_LO    = 7'h26;
  localparam logic [6:0]  BUS_ADDR_HI    = 7'h27;

  // Pin synchroniser lanes
  localparam int unsigned PIN_VCO        = 0;
  localparam int unsigned PIN_HS         = 1;
  localparam int unsigned PIN_VS         = 2;
  localparam int unsigned PIN_SUPPLY     = 3;
  localparam int unsigned PIN_ADDR       = 4;
  localparam logic [4:0]  PIN_RST        = 5'h08;

  typedef enum logic [1:0] {
    ST_SEEK = 2'b01,
    ST_LOCK = 2'b10
  } llpcc_lock_t;

endpackage

/* verilog/llpcc_sync.sv */
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Inputs asynchronous to clk
// Notes:   Output changes only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module llpcc_sync #(
  parameter int unsigned      W    = 1,
  parameter logic [W-1:0]     INIT = '0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Pins in, filtered out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  if (W < 1) begin : g_chk
    $error("llpcc_sync needs W >= 1");
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
      q    <= INIT;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q    <= (s2_r & s3_r) | (q & (s2_r ^ s3_r));
    end
  end
endmodule
`default_nettype wire

/* verilog/llpcc_top.sv */
// Purpose: Digital control of a line-locked pixel clock synthesiser
// Assumes: One 250 MHz core clock; oscillator and sync pins are sampled
// Notes:   Oscillator input must stay well below a quarter of CORE_CLK
// Behaviour
// - Feedback divider counts pixel clocks, feeds detector
// - Post-divider turns oscillator into pixel clock
// - Detector compares edges, drives pump up/down
// - Sync outputs retimed on pixel clock rising edges
// - Horizontal sync edge is the loop reference
// - Coast via vertical sync ignores reference edges
// - Lock shown on pin and in register
// - Internal power-on and brown-out reset
// - Serial bus runs standard or fast rate
// - Twelve words: one write-only, eight rw, three ro
// - Strap picks one of two device addresses
// - Pump always on, or gated by vsync polarity
// - Hsync polarity picks rising or falling edge
// - Post-divider codes give 2, 4, 8, 16
// - Feedback ratio is word plus eight, 12..4103
`timescale 1ns/1ps
`default_nettype none
module llpcc_top
  import llpcc_pkg::*;
#(
  parameter logic [15:0] PEND_LIMIT = 16'hFFFF,
  parameter logic [7:0]  IDENT_CODE = 8'h5A
) (
  // Clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        NRST,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Pins in
  input  wire logic        VCO_IN,
  input  wire logic        HSYNC_IN,
  input  wire logic        VSYNC_IN,
  input  wire logic        SUPPLY_OK,
  input  wire logic        ADDR_SEL,
  // Clock, sync and loop outputs
  output logic             PIX_CLK,
  output logic             HSYNC_OUT,
  output logic             VSYNC_OUT,
  output logic             PUMP_UP,
  output logic             PUMP_DN,
  output logic      [2:0]  PUMP_CUR,
  output logic             LOCK,
  // Serial bus setup and interrupt
  output logic      [6:0]  BUS_ADDR,
  output logic             BUS_FAST,
  output logic             IRQ
);
  // The arbitrary IDENT_CODE default carries no meaning
  if (PEND_LIMIT < 16'h0010) begin : g_chk
    $error("PEND_LIMIT must be at least 16");
  end

  logic [4:0]  pins_f;
  logic        rst_n;
  logic [15:0] por_cnt_r;
  logic        vco_d_r;
  logic        hs_d_r;
  logic        coast_d_r;
  logic [2:0]  pd_cnt_r;
  logic        pix_r;
  logic [12:0] fb_cnt_r;
  logic [12:0] ratio_r;
  logic        fb_pulse_r;
  logic        up_r;
  logic        dn_r;
  logic [15:0] pend_r;
  logic [3:0]  hit_cnt_r;
  logic [3:0]  miss_cnt_r;
  llpcc_lock_t lock_st_r;
  logic        hso_r;
  logic        vso_r;
  logic [6:0]  strap_addr_r;
  logic [7:0]  in_ctrl_r;
  logic [7:0]  loop_ctrl_r;
  logic [7:0]  fb_low_r;
  logic [3:0]  fb_high_r;
  logic [NUM_EV-1:0] mask_r;
  logic [NUM_EV-1:0] sts_r;
  logic [7:0]  tol_r;
  logic        bus_fast_r;
  logic [31:0] prdata_r;
  logic [31:0] rd_nxt;

  llpcc_sync #(
    .W    (5),
    .INIT (PIN_RST)
  ) u_pins (
    .clk   (CORE_CLK),
    .rst_n (NRST),
    .d     ({ADDR_SEL, SUPPLY_OK, VSYNC_IN, HSYNC_IN, VCO_IN}),
    .q     (pins_f)
  );

  // Internal reset: held after NRST release and while supply is low
  always_ff @(posedge CORE_CLK) begin
    if (!NRST || !pins_f[PIN_SUPPLY]) begin
      por_cnt_r <= 16'h0000;
    end else if (por_cnt_r != POR_CYC) begin
      por_cnt_r <= por_cnt_r + 16'h0001;
    end
  end
  assign rst_n = NRST && (por_cnt_r == POR_CYC);

  // Address strap sampled throughout reset, frozen at release
  always_ff @(posedge CORE_CLK) begin
    if (!rst_n) begin
      strap_addr_r <= pins_f[PIN_ADDR] ? BUS_ADDR_HI : BUS_ADDR_LO;
    end
  end

  // APB decode
  logic [3:0] idx;
  logic       mapped;
  logic       acc;
  logic       wr;
  logic [NUM_EV-1:0] ev;
  assign idx    = PADDR[5:2];
  assign mapped = (PADDR[7:6] == 2'b00) && (idx < NUM_REGS);
  assign acc    = PSEL && PENABLE;
  assign wr     = acc && PWRITE && mapped;

  always_ff @(posedge CORE_CLK) begin
    if (!rst_n) begin
      in_ctrl_r   <= INPUT_CTRL_RST;
      loop_ctrl_r <= LOOP_CTRL_RST;
      fb_low_r    <= FB_LOW_RST;
      fb_high_r   <= FB_HIGH_RST;
      mask_r      <= '0;
      tol_r       <= LOCK_TOL_RST;
      bus_fast_r  <= 1'b0;
    end else if (wr) begin
      case (idx)
        IDX_INPUT_CTRL: in_ctrl_r   <= PWDATA[7:0] & INPUT_CTRL_WMSK;
        IDX_LOOP_CTRL:  loop_ctrl_r <= PWDATA[7:0] & LOOP_CTRL_WMSK;
        IDX_FB_LOW:     fb_low_r    <= PWDATA[7:0];
        IDX_FB_HIGH:    fb_high_r   <= PWDATA[3:0];
        IDX_IRQ_MASK:   mask_r      <= PWDATA[NUM_EV-1:0];
        IDX_LOCK_TOL:   tol_r       <= PWDATA[7:0];
        IDX_BUS_CTRL:   bus_fast_r  <= PWDATA[0];
        default: ;
      endcase
    end
  end

  // Sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge CORE_CLK) begin
    if (!rst_n) begin
      sts_r <= '0;
    end else if (wr && idx == IDX_IRQ_STATUS) begin
      sts_r <= (sts_r & ~PWDATA[NUM_EV-1:0]) | ev;
    end else begin
      sts_r <= sts_r | ev;
    end
  end

  logic restart;
  assign restart = wr && (idx == IDX_COMMAND) && PWDATA[0];

  // Read data captured in the setup phase; write-only word reads zero
  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (idx)
      IDX_INPUT_CTRL: rd_nxt[7:0] = in_ctrl_r;
      IDX_LOOP_CTRL:  rd_nxt[7:0] = loop_ctrl_r;
      IDX_FB_LOW:     rd_nxt[7:0] = fb_low_r;
      IDX_FB_HIGH:    rd_nxt[3:0] = fb_high_r;
      IDX_IRQ_MASK:   rd_nxt[NUM_EV-1:0] = mask_r;
      IDX_IRQ_STATUS: rd_nxt[NUM_EV-1:0] = sts_r;
      IDX_LOCK_TOL:   rd_nxt[7:0] = tol_r;
      IDX_BUS_CTRL:   rd_nxt[0]   = bus_fast_r;
      IDX_LOOP_STAT:  rd_nxt[3:0] = {pins_f[PIN_VS], pins_f[PIN_HS], coast_d_r,
                                     lock_st_r == ST_LOCK};
      IDX_BUS_ADDR:   rd_nxt[6:0] = strap_addr_r;
      IDX_IDENT:      rd_nxt[7:0] = IDENT_CODE;
      default:        rd_nxt = 32'h0000_0000;
    endcase
    if (!mapped) begin
      rd_nxt = 32'h0000_0000;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!rst_n) begin
      prdata_r <= 32'h0000_0000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      prdata_r <= rd_nxt;
    end
  end

  assign PRDATA  = prdata_r;
  assign PREADY  = 1'b1;
  assign PSLVERR = acc && !mapped;

  // Post-divider: pixel clock toggles every 2^code rising oscillator edges
  logic       vco_rise;
  logic [3:0] pd_half;
  logic       pd_wrap;
  logic       pix_rise;
  assign vco_rise = pins_f[PIN_VCO] && !vco_d_r;
  assign pd_half  = 4'h1 << loop_ctrl_r[POST_DIV_LSB +: 2];
  assign pd_wrap  = vco_rise && (pd_cnt_r == 3'(pd_half - 4'h1));
  assign pix_rise = pd_wrap && !pix_r;

  always_ff @(posedge CORE_CLK) begin
    if (!rst_n) begin
      vco_d_r  <= 1'b0;
      pd_cnt_r <= 3'h0;
      pix_r    <= 1'b0;
    end else begin
      vco_d_r <= pins_f[PIN_VCO];
      if (pd_wrap) begin
        pd_cnt_r <= 3'h0;
        pix_r    <= !pix_r;
      end else if (vco_rise) begin
        pd_cnt_r <= pd_cnt_r + 3'h1;
      end
    end
  end

  // Feedback divider; new ratio taken at each wrap
  logic [11:0] fb_word;
  logic [12:0] ratio_nxt;
  logic        fb_wrap;
  assign fb_word   = {fb_high_r, fb_low_r};
  assign ratio_nxt = {1'b0, (fb_word < FB_MIN_WORD) ? FB_MIN_WORD : fb_word}
                     + FB_OFFSET;
  assign fb_wrap   = pix_rise && (fb_cnt_r >= ratio_r - 13'h0001);

  always_ff @(posedge CORE_CLK) begin
    if (!rst_n) begin
      fb_cnt_r   <= 13'h0000;
      ratio_r    <= FB_OFFSET + 13'(FB_MIN_WORD);
      fb_pulse_r <= 1'b0;
    end else begin
      fb_pulse_r <= fb_wrap;
      if (fb_wrap) begin
        fb_cnt_r <= 13'h0000;
        ratio_r  <= ratio_nxt;
      end else if (pix_rise) begin
        fb_cnt_r <= fb_cnt_r + 13'h0001;
      end
    end
  end

  // Reference edge and coast
  logic coast;
  logic ref_raw;
  logic ref_edge;
  assign coast    = !in_ctrl_r[BIT_PUMP_ALWAYS] &&
                    (in_ctrl_r[BIT_VS_POL] ? pins_f[PIN_VS] : !pins_f[PIN_VS]);
  assign ref_raw  = in_ctrl_r[BIT_HS_POL] ? (hs_d_r && !pins_f[PIN_HS])
                                          : (!hs_d_r && pins_f[PIN_HS]);
  assign ref_edge = ref_raw && !coast;

  // Phase-frequency detector with pending-time measure
  logic up_n;
  logic dn_n;
  logic eval;
  logic timeout;
  logic hit;
  logic miss;
  assign up_n    = up_r || ref_edge;
  assign dn_n    = dn_r || fb_pulse_r;
  assign eval    = up_n && dn_n;
  assign timeout = (up_r ^ dn_r) && (pend_r == PEND_LIMIT);
  assign hit     = eval && (pend_r <= {8'h00, tol_r});
  assign miss    = (eval && !hit) || timeout;

  always_ff @(posedge CORE_CLK) begin
    if (!rst_n) begin
      hs_d_r    <= pins_f[PIN_HS];
      coast_d_r <= 1'b0;
      up_r      <= 1'b0;
      dn_r      <= 1'b0;
      pend_r    <= 16'h0000;
    end else begin
      hs_d_r    <= pins_f[PIN_HS];
      coast_d_r <= coast;
      if (eval || timeout) begin
        up_r   <= 1'b0;
        dn_r   <= 1'b0;
        pend_r <= 16'h0000;
      end else begin
        up_r <= up_n;
        dn_r <= dn_n;
        if (up_r ^ dn_r) begin
          pend_r <= pend_r + 16'h0001;
        end
      end
    end
  end

  assign PUMP_UP  = up_r && !dn_r && !coast;
  assign PUMP_DN  = dn_r && !up_r && !coast;
  assign PUMP_CUR = loop_ctrl_r[PUMP_CUR_LSB +: 3];

  // Lock detection
  always_ff @(posedge CORE_CLK) begin
    if (!rst_n || restart) begin
      lock_st_r  <= ST_SEEK;
      hit_cnt_r  <= 4'h0;
      miss_cnt_r <= 4'h0;
    end else begin
      case (lock_st_r)
        ST_SEEK: begin
          if (hit && hit_cnt_r == LOCK_HITS - 4'h1) begin
            lock_st_r  <= ST_LOCK;
            hit_cnt_r  <= 4'h0;
            miss_cnt_r <= 4'h0;
          end else if (hit) begin
            hit_cnt_r <= hit_cnt_r + 4'h1;
          end else if (miss) begin
            hit_cnt_r <= 4'h0;
          end
        end
        ST_LOCK: begin
          if (miss && miss_cnt_r == LOCK_MISSES - 4'h1) begin
            lock_st_r  <= ST_SEEK;
            miss_cnt_r <= 4'h0;
          end else if (miss) begin
            miss_cnt_r <= miss_cnt_r + 4'h1;
          end else if (hit) begin
            miss_cnt_r <= 4'h0;
          end
        end
        default: begin
          lock_st_r <= ST_SEEK;
        end
      endcase
    end
  end

  logic lock_gain;
  logic lock_loss;
  assign lock_gain = !restart && lock_st_r == ST_SEEK && hit &&
                     hit_cnt_r == LOCK_HITS - 4'h1;
  assign lock_loss = (lock_st_r == ST_LOCK) &&
                     (restart || (miss && miss_cnt_r == LOCK_MISSES - 4'h1));
  assign ev[EV_LOCK_GAIN] = lock_gain;
  assign ev[EV_LOCK_LOSS] = lock_loss;
  assign ev[EV_COAST]     = coast && !coast_d_r;

  // Sync outputs retimed on pixel clock rising edges
  always_ff @(posedge CORE_CLK) begin
    if (!rst_n) begin
      hso_r <= 1'b0;
      vso_r <= 1'b0;
    end else if (pix_rise) begin
      hso_r <= pins_f[PIN_HS];
      vso_r <= pins_f[PIN_VS];
    end
  end

  assign PIX_CLK   = pix_r;
  assign HSYNC_OUT = hso_r;
  assign VSYNC_OUT = vso_r;
  assign LOCK      = (lock_st_r == ST_LOCK) && in_ctrl_r[BIT_LOCK_OUT_EN];
  assign BUS_ADDR  = strap_addr_r;
  assign BUS_FAST  = bus_fast_r;
  assign IRQ       = |(sts_r & mask_r);

  // Checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);

  sequence s_release;
    $rose(NRST) || $fell(pins_f[PIN_SUPPLY]);
  endsequence

  sequence s_acc_unmapped;
    PSEL && !PENABLE && !mapped ##1 PSEL && PENABLE;
  endsequence

  a_por_hold: assert property (s_release |=> !rst_n [*8])
    else $error("internal reset released too early");
  a_coast_pump: assert property (!in_ctrl_r[BIT_PUMP_ALWAYS] &&
                                 (in_ctrl_r[BIT_VS_POL] == pins_f[PIN_VS]) |-> !PUMP_UP && !PUMP_DN)
    else $error("pump active during coast");
  a_coast_ref: assert property (coast && rst_n |-> !ref_edge ##1 !(up_r && !$past(up_r)))
    else $error("reference taken during coast");
  a_pfd_exclusive: assert property (!(PUMP_UP && PUMP_DN))
    else $error("pump up and down together");
  a_post_div: assert property (rst_n && pd_wrap |=> PIX_CLK != $past(PIX_CLK))
    else $error("post-divider missed a toggle");
  a_fb_wrap_pulse: assert property (rst_n && pix_rise && fb_cnt_r == ratio_r - 13'h0001
                                   |=> fb_pulse_r && fb_cnt_r == 13'h0000)
    else $error("feedback divider wrap wrong");
  a_ratio_range: assert property (rst_n |-> ratio_r >= 13'h000C && ratio_r <= 13'h1007)
    else $error("feedback ratio out of range");
  a_hs_retime: assert property (rst_n && pix_rise ##1 rst_n |-> HSYNC_OUT == $past(pins_f[PIN_HS]))
    else $error("hsync not retimed");
  a_lock_rise: assert property (rst_n && lock_gain |=> LOCK == in_ctrl_r[BIT_LOCK_OUT_EN]
                               && sts_r[EV_LOCK_GAIN])
    else $error("lock not raised after hits");
  a_strap_addr: assert property (BUS_ADDR == BUS_ADDR_LO || BUS_ADDR == BUS_ADDR_HI)
    else $error("bus address not a strap value");
  a_unmapped_err: assert property (s_acc_unmapped |-> PSLVERR && PREADY)
    else $error("unmapped access not flagged");
endmodule
`default_nettype wire

/* verification/llpcc_video_src.sv */
// Purpose: Video source model: free-running oscillator and line sync
// Assumes: Oscillator period 8 core cycles; sync period set by the bench
// Notes:   Tracking mode slips the sync phase to null the pump outputs
`timescale 1ns/1ps
`default_nettype none
module llpcc_video_src (
  // Clock
  input  wire logic        clk,
  // Control from bench and device
  input  wire logic [15:0] period,
  input  wire logic        track,
  input  wire logic        up,
  input  wire logic        dn,
  // Pins to device
  output logic             vco,
  output logic             hsync
);
  logic [15:0] cnt_r  = '0;
  logic [1:0]  div_r  = '0;
  logic        vco_r  = 1'b0;
  logic        hs_r   = 1'b0;

  assign vco   = vco_r;
  assign hsync = hs_r;

  always @(posedge clk) begin
    div_r <= div_r + 2'd1;
    if (div_r == 2'd3) begin
      vco_r <= ~vco_r;
    end
  end

  // Line sync is the loop reference; pump feedback pulls its phase
  always @(posedge clk) begin
    if (cnt_r == 16'h0000) begin
      cnt_r <= period - 16'd1;
    end else if (track && up) begin
      cnt_r <= cnt_r;
    end else if (track && dn && cnt_r > 16'd1) begin
      cnt_r <= cnt_r - 16'd2;
    end else begin
      cnt_r <= cnt_r - 16'd1;
    end
    hs_r <= (cnt_r < 16'd40);
  end
endmodule
`default_nettype wire

/* verification/test_line_locked_pixel_clock_ctrl.sv */
// Purpose: Self-checking bench for the pixel clock controller
// Assumes: APB master tasks, video source model, 250 MHz core clock
// Notes:   Pending limit shortened to 64 cycles
`timescale 1ns/1ps
`default_nettype none
module test_line_locked_pixel_clock_ctrl;
  import llpcc_pkg::*;
  localparam logic [7:0]  IDENT = 8'hC3; // Arbitrary identity value
  localparam int          LIMIT = 60000;
  logic        core_clk, nrst, psel, penable, pwrite, pready, pslverr, er;
  logic        vsync_in, supply_ok, addr_sel, vco_in, hsync_in, pix_clk, track;
  logic        hsync_out, vsync_out, pump_up, pump_dn, lock, bus_fast, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  pump_cur;
  logic [6:0]  bus_addr;
  logic [15:0] period;
  int          errors = 0, n_tests = 0, cyc = 0, bad_retime = 0, hs_moves = 0;
  logic        mon_en = 1'b0, hd = 1'b0;
  logic [2:0]  pd = '0;

  llpcc_top #(.PEND_LIMIT(16'h0040), .IDENT_CODE(IDENT)) dut (
    .CORE_CLK(core_clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .VCO_IN(vco_in), .HSYNC_IN(hsync_in),
    .VSYNC_IN(vsync_in), .SUPPLY_OK(supply_ok), .ADDR_SEL(addr_sel),
    .PIX_CLK(pix_clk), .HSYNC_OUT(hsync_out), .VSYNC_OUT(vsync_out),
    .PUMP_UP(pump_up), .PUMP_DN(pump_dn), .PUMP_CUR(pump_cur), .LOCK(lock),
    .BUS_ADDR(bus_addr), .BUS_FAST(bus_fast), .IRQ(irq));

  llpcc_video_src src (.clk(core_clk), .period(period), .track(track),
    .up(pump_up), .dn(pump_dn), .vco(vco_in), .hsync(hsync_in));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // Sync output may only move just after a pixel clock rise; hang guard
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (mon_en && hd !== hsync_out) begin
      hs_moves++;
      if (!(pix_clk === 1'b1 && pd[2] === 1'b0)) bad_retime++;
    end
    hd <= hsync_out;
    pd <= {pd[1:0], pix_clk};
    if (cyc == LIMIT) begin
      errors++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    if (errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    @(posedge core_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= addr; pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic w(input logic [3:0] idx, input logic [31:0] d);
    apb(1'b1, {2'b00, idx, 2'b00}, d);
  endtask

  task automatic rchk(input string what, input logic [3:0] idx, input logic [31:0] exp,
                      input logic [31:0] msk);
    apb(1'b0, {2'b00, idx, 2'b00}, 32'h0000_0000);
    chk(what, exp, rd & msk);
  endtask

  task automatic wait_lock(input logic want);
    for (int n = 0; n < 8000 && lock !== want; n++) @(posedge core_clk);
    chk("lock pin", {31'h0, want}, {31'h0, lock});
  endtask

  task automatic t_reset;
    chk("bus addr", 32'h26, {25'h0, bus_addr});
    chk("bus fast", 32'h0, {31'h0, bus_fast});
    rchk("input ctrl", IDX_INPUT_CTRL, 32'h41, 32'hFF);
    rchk("loop ctrl", IDX_LOOP_CTRL, 32'h03, 32'hFF);
    rchk("fb low", IDX_FB_LOW, 32'h04, 32'hFF);
    rchk("fb high", IDX_FB_HIGH, 32'h00, 32'hFF);
    rchk("irq mask", IDX_IRQ_MASK, 32'h00, 32'hFF);
    rchk("lock tol", IDX_LOCK_TOL, 32'h0A, 32'hFF);
    rchk("command", IDX_COMMAND, 32'h00, 32'hFFFF_FFFF);
    rchk("ident", IDX_IDENT, {24'h0, IDENT}, 32'hFF);
    rchk("bus addr reg", IDX_BUS_ADDR, 32'h26, 32'hFF);
  endtask

  task automatic t_access;
    w(IDX_INPUT_CTRL, 32'hFF);
    rchk("input ctrl mask", IDX_INPUT_CTRL, 32'h47, 32'hFFFF_FFFF);
    w(IDX_INPUT_CTRL, 32'h41);
    w(IDX_LOOP_CTRL, 32'hFF);
    @(posedge core_clk);
    chk("pump cur", 32'h7, {29'h0, pump_cur});
    rchk("loop ctrl mask", IDX_LOOP_CTRL, 32'h37, 32'hFFFF_FFFF);
    w(IDX_LOOP_CTRL, 32'h03);
    w(IDX_FB_HIGH, 32'hF0);
    rchk("fb high mask", IDX_FB_HIGH, 32'h00, 32'hFF);
    w(IDX_FB_HIGH, 32'h00);
    w(IDX_IDENT, 32'h00);
    rchk("ident ro", IDX_IDENT, {24'h0, IDENT}, 32'hFF);
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, 8'h80, 32'hFF);
    chk("high addr err", 32'h1, {31'h0, er});
    w(IDX_BUS_CTRL, 32'h01);
    @(posedge core_clk);
    chk("bus fast", 32'h1, {31'h0, bus_fast});
    rchk("bus ctrl", IDX_BUS_CTRL, 32'h01, 32'hFF);
  endtask

  task automatic t_lock;
    w(IDX_IRQ_MASK, 32'h01);
    wait_lock(1'b1);
    rchk("status locked", IDX_LOOP_STAT, 32'h1, 32'h1);
    chk("irq gain", 32'h1, {31'h0, irq});
    rchk("gain event", IDX_IRQ_STATUS, 32'h1, 32'h1);
    w(IDX_IRQ_STATUS, 32'h01);
    rchk("gain cleared", IDX_IRQ_STATUS, 32'h0, 32'h1);
    chk("irq cleared", 32'h0, {31'h0, irq});
    w(IDX_INPUT_CTRL, 32'h01);
    @(posedge core_clk);
    chk("lock pin off", 32'h0, {31'h0, lock});
    w(IDX_INPUT_CTRL, 32'h41);
  endtask

  task automatic t_polarity;
    track <= 1'b0;
    w(IDX_INPUT_CTRL, 32'h45);
    wait_lock(1'b0);
    rchk("loss event", IDX_IRQ_STATUS, 32'h2, 32'h2);
    track <= 1'b1;
    wait_lock(1'b1);
  endtask

  task automatic t_ratio;
    w(IDX_IRQ_STATUS, 32'h07);
    w(IDX_FB_LOW, 32'h10);
    period <= 16'd384;
    w(IDX_COMMAND, 32'h01);
    @(posedge core_clk);
    chk("restart drops", 32'h0, {31'h0, lock});
    rchk("restart loss", IDX_IRQ_STATUS, 32'h2, 32'h2);
    wait_lock(1'b1);
    w(IDX_FB_LOW, 32'h00);
    period <= 16'd192;
    w(IDX_COMMAND, 32'h01);
    @(posedge core_clk);
    chk("restart again", 32'h0, {31'h0, lock});
    wait_lock(1'b1);
  endtask

  task automatic t_postdiv;
    time t0;
    for (int code = 0; code < 4; code++) begin
      w(IDX_LOOP_CTRL, {26'h0, code[1:0], 4'h3});
      repeat (3) @(posedge pix_clk);
      t0 = $time;
      @(posedge pix_clk);
      chk("pix period", 32'd16 << code, 32'(($time - t0) / 4));
    end
    w(IDX_LOOP_CTRL, 32'h03);
  endtask

  task automatic t_coast;
    int act;
    act = 0;
    w(IDX_IRQ_STATUS, 32'h07);
    w(IDX_IRQ_MASK, 32'h00);
    w(IDX_INPUT_CTRL, 32'h46);
    vsync_in <= 1'b1;
    repeat (10) @(posedge core_clk);
    for (int n = 0; n < 400; n++) begin
      @(posedge core_clk);
      if (pump_up !== 1'b0 || pump_dn !== 1'b0) act++;
    end
    chk("pumps in coast", 32'h0, act);
    rchk("coast event", IDX_IRQ_STATUS, 32'h4, 32'h4);
    rchk("coast state", IDX_LOOP_STAT, 32'h2, 32'h2);
    chk("irq masked", 32'h0, {31'h0, irq});
    chk("vsync out", 32'h1, {31'h0, vsync_out});
    w(IDX_IRQ_MASK, 32'h04);
    @(posedge core_clk);
    chk("irq coast", 32'h1, {31'h0, irq});
    w(IDX_IRQ_STATUS, 32'h04);
    @(posedge core_clk);
    chk("irq w1c", 32'h0, {31'h0, irq});
    vsync_in <= 1'b0;
    w(IDX_INPUT_CTRL, 32'h44);
    repeat (10) @(posedge core_clk);
    rchk("coast low pol", IDX_LOOP_STAT, 32'h2, 32'h2);
    w(IDX_INPUT_CTRL, 32'h45);
    repeat (4) @(posedge core_clk);
    rchk("pump always", IDX_LOOP_STAT, 32'h0, 32'h2);
  endtask

  task automatic t_brownout;
    mon_en <= 1'b0;
    addr_sel <= 1'b1;
    supply_ok <= 1'b0;
    repeat (8) @(posedge core_clk);
    supply_ok <= 1'b1;
    repeat (266) @(posedge core_clk);
    chk("strap addr", 32'h27, {25'h0, bus_addr});
    chk("lock reset", 32'h0, {31'h0, lock});
    chk("fast reset", 32'h0, {31'h0, bus_fast});
    rchk("bus addr hi", IDX_BUS_ADDR, 32'h27, 32'hFF);
    rchk("ctrl reset", IDX_INPUT_CTRL, 32'h41, 32'hFF);
  endtask

  initial begin
    nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    vsync_in = 1'b0; supply_ok = 1'b1; addr_sel = 1'b0; period = 16'd192; track = 1'b1;
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (262) @(posedge core_clk);
    mon_en <= 1'b1;
    t_reset();
    t_access();
    t_lock();
    t_polarity();
    t_ratio();
    t_postdiv();
    t_coast();
    chk("retime faults", 32'h0, bad_retime);
    chk("hsync moved", 32'h1, {31'h0, hs_moves > 0});
    t_brownout();
    wrap_up();
  end
endmodule
`default_nettype wire
